// file: lsk_pkg.sv
// Package of constants and types shared by the lockstep checker files.
package lsk_pkg;

	// Bus and register geometry.
	localparam int unsigned LSK_ADDR_W      = 16;
	localparam int unsigned LSK_DATA_W      = 8;
	localparam int unsigned LSK_APB_ADDR_W  = 12;
	localparam int unsigned LSK_SEGMENTS    = 3;

	// Register byte offsets on the APB slave.
	localparam logic [11:0] LSK_OFS_CONTROL  = 12'h000;
	localparam logic [11:0] LSK_OFS_INT_STAT = 12'h004;
	localparam logic [11:0] LSK_OFS_INT_MASK = 12'h008;
	localparam logic [11:0] LSK_OFS_STATUS   = 12'h00c;

	// Field positions of the control register.
	localparam int unsigned LSK_BIT_FORCE_ADDR_LOW  = 0;
	localparam int unsigned LSK_BIT_FORCE_ADDR_HIGH = 1;
	localparam int unsigned LSK_BIT_FORCE_DATA      = 2;
	localparam int unsigned LSK_BIT_FAULT_SET       = 7;

	// Field positions of the status register.
	localparam int unsigned LSK_BIT_STAT_FAULT     = 0;
	localparam int unsigned LSK_BIT_STAT_RESETTING = 1;
	localparam int unsigned LSK_BIT_STAT_MISMATCH  = 2;

	// Reset values.
	localparam logic [2:0] LSK_FORCE_RESET = 3'h0;
	localparam logic [2:0] LSK_MASK_RESET  = 3'h0;

	// Internal reset pulse length.
	localparam int unsigned LSK_RESET_TIME_NS   = 320;
	localparam int unsigned LSK_CLK_PERIOD_NS   = 10;
	localparam int unsigned LSK_RESET_CYCLES    =
		(LSK_RESET_TIME_NS + LSK_CLK_PERIOD_NS - 1) / LSK_CLK_PERIOD_NS;
	localparam int unsigned LSK_RESET_CNT_W     = 6;

	// One machine cycle as seen on a processor's bus side.
	typedef struct packed {
		logic                  valid;
		logic                  write;
		logic [LSK_ADDR_W-1:0] addr;
		logic [LSK_DATA_W-1:0] wdata;
	} lsk_cycle_t;

endpackage

// file: lsk_segment_compare.sv
// One compare segment of the lockstep checker: a byte compare with a force input.
`timescale 1ns/1ps
`default_nettype none
module lsk_segment_compare (
	// Compared values.
	input  wire logic [7:0] primary_byte,
	input  wire logic [7:0] duplicate_byte,
	// Qualifiers.
	input  wire logic       compare_en,
	input  wire logic       force_mismatch,
	// Result.
	output logic            mismatch
);
	import lsk_pkg::*;

	// A forced test mismatch reports exactly like a real one.
	always_comb begin
		mismatch = force_mismatch | (compare_en & (primary_byte != duplicate_byte));
	end

endmodule
`default_nettype wire

// file: lsk_reset_stretch.sv
// Internal reset generator shared by the checker and the other internal reset sources.
`timescale 1ns/1ps
`default_nettype none
module lsk_reset_stretch (
	// Clock and power-on reset.
	input  wire logic pclk,
	input  wire logic presetn,
	// Requests.
	input  wire logic error_req,
	input  wire logic other_req,
	// Results.
	output logic      int_reset,
	output logic      error_reset
);
	import lsk_pkg::*;

	logic [LSK_RESET_CNT_W-1:0] count;
	logic [LSK_RESET_CNT_W-1:0] next_count;

	// Every source restarts the same fixed-length pulse, so a mismatch reset looks like any other.
	always_comb begin
		next_count = count;
		if (error_req || other_req) begin
			next_count = LSK_RESET_CNT_W'(LSK_RESET_CYCLES);
		end else if (count != '0) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	// Pulse output is registered from the next counter state, so it tracks the count.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_reset <= 1'b0;
		end else begin
			int_reset <= (next_count != '0);
		end
	end

	// Marks a pulse that a mismatch started, so the status register can tell it apart.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			error_reset <= 1'b0;
		end else if (error_req) begin
			error_reset <= 1'b1;
		end else if (next_count == '0) begin
			error_reset <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// file: lsk_checker.sv
// Lockstep checker top: compares a duplicate core with the primary core, APB registers.
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module lsk_checker (
	// Clock and power-on reset.
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	// APB slave.
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [11:0]                   paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	// Primary core machine cycle and system read data.
	input  wire lsk_pkg::lsk_cycle_t           primary_cycle,
	input  wire logic [7:0]                    system_rdata,
	// Duplicate core machine cycle.
	input  wire lsk_pkg::lsk_cycle_t           duplicate_cycle,
	// Shared data buffer toward the duplicate core.
	output logic      [7:0]                    duplicate_rdata,
	output logic                               duplicate_rdata_oe,
	// Other internal reset sources of the chip.
	input  wire logic                          other_reset_req,
	// Resets and fault pin.
	output logic                               int_reset,
	output logic                               fault_out_n,
	// Interrupt.
	output logic                               irq
);
	import lsk_pkg::*;

	// Control and status state.
	logic [2:0] force_bits;
	logic [2:0] force_pulse;
	logic       fault;
	logic [2:0] int_stat;
	logic [2:0] int_mask;

	// Compare results.
	logic [2:0] seg_mismatch;
	logic       any_mismatch;
	logic       error_reset;
	logic       mismatch_reset_req;

	// APB decode.
	logic       apb_setup;
	logic       apb_access;
	logic       wr_en;
	logic       addr_hit;
	logic       wr_control;
	logic       wr_int_stat;
	logic       wr_int_mask;

	// Byte enables for each segment are only meaningful outside a reset pulse.
	logic       cycle_live;
	logic       data_compare_en;

	// Decodes a mapped register offset.
	function automatic logic is_mapped(input logic [11:0] a);
		is_mapped = (a == LSK_OFS_CONTROL) || (a == LSK_OFS_INT_STAT) ||
		            (a == LSK_OFS_INT_MASK) || (a == LSK_OFS_STATUS);
	endfunction

	// APB phases; the slave never adds wait states.
	assign apb_setup  = psel & ~penable;
	assign apb_access = psel & penable;
	assign addr_hit   = is_mapped(paddr);
	assign wr_en      = apb_access & pwrite & addr_hit;
	assign pready     = 1'b1;

	// One strobe per writable register keeps the offset decode in one place.
	assign wr_control  = wr_en & (paddr == LSK_OFS_CONTROL);
	assign wr_int_stat = wr_en & (paddr == LSK_OFS_INT_STAT);
	assign wr_int_mask = wr_en & (paddr == LSK_OFS_INT_MASK);

	// Both cores see one reset and one clock, so they stay in step after every reset.
	assign cycle_live = primary_cycle.valid & ~int_reset;

	// Data is compared only on write cycles of the primary.
	assign data_compare_en = cycle_live & primary_cycle.write;

	// Shared buffer feeds the duplicate on reads and floats on writes.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			duplicate_rdata <= 8'h00;
		end else begin
			duplicate_rdata <= system_rdata;
		end
	end

	// Buffer enable follows the current cycle direction so the duplicate drives its own writes.
	assign duplicate_rdata_oe = ~(primary_cycle.valid & primary_cycle.write);

	// Low address byte segment.
	lsk_segment_compare u_cmp_addr_low (
		.primary_byte   (primary_cycle.addr[7:0]),
		.duplicate_byte (duplicate_cycle.addr[7:0]),
		.compare_en     (cycle_live),
		.force_mismatch (force_pulse[LSK_BIT_FORCE_ADDR_LOW]),
		.mismatch       (seg_mismatch[LSK_BIT_FORCE_ADDR_LOW])
	);

	// High address byte segment.
	lsk_segment_compare u_cmp_addr_high (
		.primary_byte   (primary_cycle.addr[15:8]),
		.duplicate_byte (duplicate_cycle.addr[15:8]),
		.compare_en     (cycle_live),
		.force_mismatch (force_pulse[LSK_BIT_FORCE_ADDR_HIGH]),
		.mismatch       (seg_mismatch[LSK_BIT_FORCE_ADDR_HIGH])
	);

	// Write data segment.
	lsk_segment_compare u_cmp_data (
		.primary_byte   (primary_cycle.wdata),
		.duplicate_byte (duplicate_cycle.wdata),
		.compare_en     (data_compare_en),
		.force_mismatch (force_pulse[LSK_BIT_FORCE_DATA]),
		.mismatch       (seg_mismatch[LSK_BIT_FORCE_DATA])
	);

	assign any_mismatch       = |seg_mismatch;
	assign mismatch_reset_req = any_mismatch;

	// One pulse generator serves the mismatch and every other internal source.
	lsk_reset_stretch u_reset (
		.pclk        (pclk),
		.presetn     (presetn),
		.error_req   (mismatch_reset_req),
		.other_req   (other_reset_req),
		.int_reset   (int_reset),
		.error_reset (error_reset)
	);

	// A write with any force bit at 1 fires a one-cycle forced mismatch next cycle.
	// A level force would hold the chip in reset forever, hence the single pulse.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			force_pulse <= 3'h0;
		end else if (wr_control) begin
			force_pulse <= pwdata[2:0];
		end else begin
			force_pulse <= 3'h0;
		end
	end

	// Force bits record the failing segment; a failure wins over a clearing write.
	// They live on the power-on reset only, so software can read them after the pulse.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			force_bits <= LSK_FORCE_RESET;
		end else if (wr_control) begin
			force_bits <= pwdata[2:0] | seg_mismatch;
		end else begin
			force_bits <= force_bits | seg_mismatch;
		end
	end

	// Fault latch: set only by a mismatch, cleared by writing 0 to bit 7 or power-on.
	// Other internal reset sources do not touch it; the set wins over a same-cycle clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault <= 1'b0;
		end else if (mismatch_reset_req) begin
			fault <= 1'b1;
		end else if (wr_control && !pwdata[LSK_BIT_FAULT_SET]) begin
			fault <= 1'b0;
		end
	end

	// Pin is driven from the latch; int_reset is deliberately not an input here.
	assign fault_out_n = ~fault;

	// Sticky interrupt status per segment, write one to clear, set wins.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_stat <= 3'h0;
		end else if (wr_int_stat) begin
			int_stat <= (int_stat & ~pwdata[2:0]) | seg_mismatch;
		end else begin
			int_stat <= int_stat | seg_mismatch;
		end
	end

	// Interrupt mask, a one enables the matching status bit.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_mask <= LSK_MASK_RESET;
		end else if (wr_int_mask) begin
			int_mask <= pwdata[2:0];
		end
	end

	// Level interrupt from registered status and mask.
	assign irq = |(int_stat & int_mask);

	// Read data and error are captured in the setup phase and stand through the access phase.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (apb_setup) begin
			prdata <= 32'h0000_0000;
			if (!pwrite) begin
				unique case (paddr)
					LSK_OFS_CONTROL: begin
						prdata[2:0] <= force_bits;
					end
					LSK_OFS_INT_STAT: begin
						prdata[2:0] <= int_stat;
					end
					LSK_OFS_INT_MASK: begin
						prdata[2:0] <= int_mask;
					end
					LSK_OFS_STATUS: begin
						prdata[LSK_BIT_STAT_FAULT]     <= fault;
						prdata[LSK_BIT_STAT_RESETTING] <= int_reset;
						// Tells a mismatch pulse apart from one that another source started.
						prdata[LSK_BIT_STAT_MISMATCH]  <= error_reset;
					end
					default: begin
						prdata <= 32'h0000_0000;
					end
				endcase
			end
		end
	end

	// Unmapped offsets answer with an error and have no effect.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else if (apb_setup) begin
			pslverr <= ~addr_hit;
		end
	end

endmodule
`default_nettype wire

// file: lsk_checker_sva.sv
// Assertion checker for the lockstep compare block, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module lsk_checker_sva (
	// Clock, reset and APB.
	input wire logic                pclk,
	input wire logic                presetn,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [11:0]         paddr,
	input wire logic [31:0]         pwdata,
	input wire logic [31:0]         prdata,
	// Core cycles and shared buffer.
	input wire lsk_pkg::lsk_cycle_t primary_cycle,
	input wire lsk_pkg::lsk_cycle_t duplicate_cycle,
	input wire logic                duplicate_rdata_oe,
	// Resets and fault pin.
	input wire logic                other_reset_req,
	input wire logic                int_reset,
	input wire logic                fault_out_n
);
	import lsk_pkg::*;
	logic live;
	logic ctl_wr;
	logic clr_wr;
	// Compares only count while a cycle is valid and no internal reset runs.
	assign live = primary_cycle.valid && !int_reset;
	assign ctl_wr = psel && penable && pwrite && paddr == LSK_OFS_CONTROL;
	assign clr_wr = ctl_wr && !pwdata[7];
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_addr_low;
		live && primary_cycle.addr[7:0] != duplicate_cycle.addr[7:0] |=> int_reset && !fault_out_n;
	endproperty
	a_addr_low: assert property (p_addr_low) else $error("low address miss not caught");
	property p_addr_high;
		live && primary_cycle.addr[15:8] != duplicate_cycle.addr[15:8] |=> int_reset && !fault_out_n;
	endproperty
	a_addr_high: assert property (p_addr_high) else $error("high address miss not caught");
	property p_data_wr;
		live && primary_cycle.write && primary_cycle.wdata != duplicate_cycle.wdata |=> !fault_out_n;
	endproperty
	a_data_wr: assert property (p_data_wr) else $error("write data miss not caught");
	// Psel low now and before means no forced compare can be pending.
	property p_read_skip;
		live && !primary_cycle.write && primary_cycle.addr == duplicate_cycle.addr && fault_out_n
			&& !psel && !$past(psel) |=> fault_out_n;
	endproperty
	a_read_skip: assert property (p_read_skip) else $error("read data was compared");
	property p_buf_float;
		primary_cycle.valid && primary_cycle.write |-> !duplicate_rdata_oe;
	endproperty
	a_buf_float: assert property (p_buf_float) else $error("buffer driven on write");
	property p_force;
		ctl_wr && pwdata[2:0] != 3'h0 |=> ##1 int_reset && !fault_out_n;
	endproperty
	a_force: assert property (p_force) else $error("force write gave no reset");
	property p_other_keep;
		other_reset_req && !primary_cycle.valid && !psel && !$past(psel)
			|=> int_reset && $stable(fault_out_n);
	endproperty
	a_other_keep: assert property (p_other_keep) else $error("other reset moved fault");
	property p_fault_hold;
		!fault_out_n && !clr_wr |=> !fault_out_n;
	endproperty
	a_fault_hold: assert property (p_fault_hold) else $error("fault released early");
	property p_fault_clear;
		$rose(fault_out_n) |-> $past(clr_wr);
	endproperty
	a_fault_clear: assert property (p_fault_clear) else $error("fault released alone");
	property p_bit7_zero;
		psel && penable && !pwrite && paddr == LSK_OFS_CONTROL |-> !prdata[7];
	endproperty
	a_bit7_zero: assert property (p_bit7_zero) else $error("fault set bit read 1");
	// Main scenarios: a forced reset, a raised fault and a cleared fault.
	c_force: cover property (ctl_wr && pwdata[2:0] != 3'h0);
	c_fault: cover property ($fell(fault_out_n));
	c_clear: cover property ($rose(fault_out_n));
endmodule
bind lsk_checker lsk_checker_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .primary_cycle, .duplicate_cycle, .duplicate_rdata_oe,
	.other_reset_req, .int_reset, .fault_out_n);
`default_nettype wire

// file: lsk_core_model.sv
// Behavioural primary and duplicate core pair feeding the lockstep block.
`timescale 1ns/1ps
`default_nettype none
module lsk_core_model (
	// Clock, reset and core hold.
	input  wire logic           pclk,
	input  wire logic           presetn,
	input  wire logic           int_reset,
	// Stream control from the bench.
	input  wire logic           run,
	input  wire logic           wr_en,
	input  wire logic [1:0]     corrupt,
	// Core cycles and system read data.
	output lsk_pkg::lsk_cycle_t primary_cycle,
	output lsk_pkg::lsk_cycle_t duplicate_cycle,
	output logic [7:0]          system_rdata
);
	import lsk_pkg::*;
	logic [7:0] cnt;
	// The stream moves every cycle, so idle lines never repeat the last value.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 8'h00;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
	assign system_rdata = cnt ^ 8'h3c;
	// Cores stop while held in reset; registers start defined, so both agree.
	always_comb begin
		primary_cycle.valid = run && !int_reset;
		primary_cycle.write = wr_en && cnt[0];
		primary_cycle.addr = {cnt ^ 8'h5a, cnt};
		primary_cycle.wdata = ~cnt;
	end
	// The duplicate differs only in the segment that the bench names.
	always_comb begin
		duplicate_cycle.valid = run && !int_reset;
		duplicate_cycle.write = wr_en && cnt[0];
		duplicate_cycle.addr = {cnt ^ 8'h5a ^ {7'h00, corrupt == 2'h2}, cnt ^ {7'h00, corrupt == 2'h1}};
		duplicate_cycle.wdata = ~cnt ^ {7'h00, corrupt == 2'h3};
	end
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking testbench for the lockstep compare block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import lsk_pkg::*;
	typedef struct {logic [1:0] corrupt; logic wr_en; logic fault_n; logic [2:0] bits;} lsk_row_t;
	lsk_row_t    rows [5] = '{'{2'h0, 1'h1, 1'h1, 3'h0}, '{2'h1, 1'h1, 1'h0, 3'h1},
		'{2'h2, 1'h1, 1'h0, 3'h2}, '{2'h3, 1'h1, 1'h0, 3'h4}, '{2'h3, 1'h0, 1'h1, 3'h0}};
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        other_reset_req = 1'b0, run = 1'b0, wr_en = 1'b0, slv;
	logic [1:0]  corrupt = 2'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd, prdata;
	logic        pready, pslverr, int_reset, fault_out_n, irq, oe;
	logic [7:0]  sys_rd, dup_rd, sys_prev;
	lsk_cycle_t  pri, dup;
	int          mismatches = 0, compares = 0, cycles = 0;
	always #5 pclk = ~pclk;
	lsk_checker dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .primary_cycle(pri), .system_rdata(sys_rd), .duplicate_cycle(dup),
		.duplicate_rdata(dup_rd), .duplicate_rdata_oe(oe), .other_reset_req, .int_reset,
		.fault_out_n, .irq);
	lsk_core_model core (.pclk, .presetn, .int_reset, .run, .wr_en, .corrupt,
		.primary_cycle(pri), .duplicate_cycle(dup), .system_rdata(sys_rd));
	// A hung wait is cut off here instead of leaving the run open.
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			print_verdict();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One APB transfer; the request holds until pready is seen at an edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic print_verdict();
		$display("Compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 12'(i * 4), 32'h0);
			chk(rd, 32'h0);
			chk(slv, 1'b0);
		end
		chk(fault_out_n, 1'b1);
		chk(pready, 1'b1);
		$display("Reset test done");
		apb(1'b1, LSK_OFS_INT_MASK, 32'h7);
		// Every row but the first corrupts one segment of the duplicate for four cycles.
		foreach (rows[i]) begin
			apb(1'b1, LSK_OFS_CONTROL, 32'h0);
			apb(1'b1, LSK_OFS_INT_STAT, 32'h7);
			while (int_reset !== 1'b0) @(posedge pclk);
			wr_en <= rows[i].wr_en;
			corrupt <= rows[i].corrupt;
			sys_prev = sys_rd;
			run <= 1'b1;
			// Values read at the edge are the settled ones of the cycle just ending.
			repeat (4) begin
				@(posedge pclk);
				chk(oe, !(pri.valid && pri.write));
				chk(dup_rd, sys_prev);
				sys_prev = sys_rd;
			end
			run <= 1'b0;
			@(posedge pclk);
			#1;
			chk(fault_out_n, rows[i].fault_n);
			chk(irq, |rows[i].bits);
			apb(1'b0, LSK_OFS_CONTROL, 32'h0);
			chk(rd, {29'h0, rows[i].bits});
			$display("Row %0d done", i);
		end
		// Each force bit alone must start a reset two edges after the write.
		for (int k = 0; k < 3; k++) begin
			while (int_reset !== 1'b0) @(posedge pclk);
			apb(1'b1, LSK_OFS_CONTROL, 32'h80 | (32'h1 << k));
			repeat (2) @(posedge pclk);
			#1;
			chk(int_reset, 1'b1);
			chk(fault_out_n, 1'b0);
			apb(1'b0, LSK_OFS_CONTROL, 32'h0);
			chk(rd, 32'h1 << k);
			apb(1'b0, LSK_OFS_STATUS, 32'h0);
			chk(rd, 32'h7);
		end
		apb(1'b1, LSK_OFS_CONTROL, 32'h80);
		#1;
		chk(fault_out_n, 1'b0);
		apb(1'b1, LSK_OFS_CONTROL, 32'h0);
		#1;
		chk(fault_out_n, 1'b1);
		$display("Force test done");
		while (int_reset !== 1'b0) @(posedge pclk);
		other_reset_req <= 1'b1;
		@(posedge pclk);
		other_reset_req <= 1'b0;
		@(posedge pclk);
		#1;
		chk(int_reset, 1'b1);
		chk(fault_out_n, 1'b1);
		apb(1'b0, LSK_OFS_STATUS, 32'h0);
		chk(rd, 32'h2);
		// Status still holds the forced events: mask, unmask, then clear.
		apb(1'b1, LSK_OFS_INT_MASK, 32'h0);
		#1;
		chk(irq, 1'b0);
		apb(1'b1, LSK_OFS_INT_MASK, 32'h7);
		#1;
		chk(irq, 1'b1);
		apb(1'b1, LSK_OFS_INT_STAT, 32'h7);
		#1;
		chk(irq, 1'b0);
		apb(1'b0, 12'h010, 32'h0);
		chk(slv, 1'b1);
		chk(rd, 32'h0);
		$display("Other reset and interrupt test done");
		// A power-on reset in mid-run must drop a standing fault and all state.
		apb(1'b1, LSK_OFS_CONTROL, 32'h81);
		repeat (2) @(posedge pclk);
		#1;
		chk(fault_out_n, 1'b0);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		chk(fault_out_n, 1'b1);
		chk(int_reset, 1'b0);
		chk(irq, 1'b0);
		apb(1'b0, LSK_OFS_CONTROL, 32'h0);
		chk(rd, 32'h0);
		$display("Power-on reset test done");
		print_verdict();
	end
endmodule
`default_nettype wire
